// *** design/dlpp_top.sv ***
// Device link power policy: decides when to ask the link for U1, U2
// or a return to U0.
// Assumes all inputs come from link and protocol logic on mclk.
`include "dlpp_defs.svh"
`default_nettype none

module dlpp_top #(
  parameter int ERDY_TMO_US = `DLPP_ERDY_TMO_US,
  parameter int BI_US = `DLPP_BI_US
) (
  input wire logic mclk, // 40 MHz clock
  input wire logic resetn, // Async reset, low
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic ctl_busy, // Control transfer in progress
  input wire logic tx_pend, // Packet waiting to transmit
  input wire logic bi_sync, // Bus interval boundary pulse
  input wire logic [1:0] link_state, // Present link state
  input wire logic [dlpp_pkg::EP_NUM-1:0] ep_nrdy, // NRDY sent
  input wire logic [dlpp_pkg::EP_NUM-1:0] ep_pp_clr, // ACK, none pending
  input wire logic [dlpp_pkg::EP_NUM-1:0] ep_pp_set, // ACK, pending
  input wire logic [dlpp_pkg::EP_NUM-1:0] ep_erdy_sent, // ERDY sent
  input wire logic [dlpp_pkg::EP_NUM-1:0] ep_erdy_ans, // Host answered ERDY
  input wire logic [dlpp_pkg::EP_NUM-1:0] ep_burst_end, // End of burst seen
  input wire logic [dlpp_pkg::EP_NUM-1:0] ep_last_pkt, // Last packet seen
  input wire logic [dlpp_pkg::EP_NUM-1:0] ep_interval, // Service interval start
  output logic req_u1, // Ask link for U1
  output logic req_u2, // Ask link for U2
  output logic req_u0 // Ask link back to U0
);
  import dlpp_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [4:0] ctrl_r;
  logic [23:0] sel_r;
  logic [15:0] guard_r;
  logic [15:0] hint_r;
  logic [7:0] eptype_r;
  logic [15:0] cnt_u1_r;
  logic [15:0] cnt_u2_r;
  logic [31:0] rdata_r;
  logic [5:0] div_r;
  logic us_tick;
  logic [15:0] bi_cnt_r;
  logic [15:0] bi_remain;
  dlpp_st_type st_r;
  dlpp_st_type st_nxt;
  logic [EP_NUM-1:0] ep_idle;
  logic [EP_NUM-1:0] ep_erdy;
  logic erdy_any;
  logic all_idle;
  logic link_u0;
  logic link_lp;
  logic [15:0] u1_lat;
  logic [15:0] u2_lat;
  logic [16:0] u2_thr;
  logic want_u2;
  logic ts_blk1;
  logic ts_blk2;
  logic ts_wake;
  logic allow_lp;
  logic allow_u1;
  logic allow_u2;
  logic need_u0;
  logic [6:0] wsel;
  logic [6:0] rsel;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic [6:0] dlpp_decode(input logic [7:0] a);
    logic [6:0] hit;
    hit = 7'h00;
    unique case (a)
      `DLPP_OFS_CTRL: hit = 7'h01;
      `DLPP_OFS_SEL: hit = 7'h02;
      `DLPP_OFS_GUARD: hit = 7'h04;
      `DLPP_OFS_HINT: hit = 7'h08;
      `DLPP_OFS_EPTYPE: hit = 7'h10;
      `DLPP_OFS_STATUS: hit = 7'h20;
      `DLPP_OFS_COUNT: hit = 7'h40;
      default: hit = 7'h00;
    endcase
    return hit;
  endfunction : dlpp_decode

  assign wsel = reg_wr ? dlpp_decode(reg_addr) : 7'h00;
  assign rsel = reg_rd ? dlpp_decode(reg_addr) : 7'h00;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= `DLPP_CTRL_RST;
    end else if (wsel[0]) begin
      ctrl_r <= reg_wdata[4:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sel_r <= `DLPP_SEL_RST;
    end else if (wsel[1]) begin
      sel_r <= reg_wdata[23:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      guard_r <= `DLPP_GUARD_RST;
    end else if (wsel[2]) begin
      guard_r <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      eptype_r <= `DLPP_EPTYPE_RST;
    end else if (wsel[4]) begin
      eptype_r <= reg_wdata[7:0];
    end
  end

  // Known unused period, counts down in microseconds
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hint_r <= 16'h0000;
    end else if (wsel[3]) begin
      hint_r <= reg_wdata[15:0];
    end else if (us_tick && hint_r != 16'h0000) begin
      hint_r <= hint_r - 16'h0001;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 32'h00000000;
    end else begin
      unique case (1'b1)
        rsel[0]: rdata_r <= {27'h0000000, ctrl_r};
        rsel[1]: rdata_r <= {8'h00, sel_r};
        rsel[2]: rdata_r <= {16'h0000, guard_r};
        rsel[3]: rdata_r <= {16'h0000, hint_r};
        rsel[4]: rdata_r <= {24'h000000, eptype_r};
        rsel[5]: rdata_r <= {15'h0000, st_r, ep_erdy, 2'h0, link_state,
                             need_u0, allow_lp, ep_idle};
        rsel[6]: rdata_r <= {cnt_u2_r, cnt_u1_r};
        default: rdata_r <= 32'h00000000;
      endcase
    end
  end

  assign reg_rdata = rdata_r;

  // ----------------------------------------
  // Microsecond tick
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_r <= 6'h00;
    end else if (div_r == 6'(`DLPP_TICK_CYC - 1)) begin
      div_r <= 6'h00;
    end else begin
      div_r <= div_r + 6'h01;
    end
  end

  assign us_tick = (div_r == 6'(`DLPP_TICK_CYC - 1));

  // ----------------------------------------
  // Endpoint trackers
  // ----------------------------------------
  generate
    for (genvar i = 0; i < EP_NUM; i++) begin : g_ep
      dlpp_ep_if epi ();
      assign epi.kind = dlpp_ep_kind_type'(eptype_r[2*i +: 2]);
      assign epi.nrdy = ep_nrdy[i];
      assign epi.pp_clr = ep_pp_clr[i];
      assign epi.pp_set = ep_pp_set[i];
      assign epi.erdy_sent = ep_erdy_sent[i];
      assign epi.erdy_ans = ep_erdy_ans[i];
      assign epi.burst_end = ep_burst_end[i];
      assign epi.last_pkt = ep_last_pkt[i];
      assign epi.interval = ep_interval[i];
      assign epi.us_tick = us_tick;
      assign epi.configured = ctrl_r[`DLPP_CTRL_CONFIG];
      assign epi.ctl_busy = ctl_busy;
      assign epi.erdy_any = erdy_any;
      assign ep_idle[i] = epi.idle;
      assign ep_erdy[i] = epi.erdy_pend;
      dlpp_ep_track #(
        .ERDY_TMO_US(ERDY_TMO_US)
      ) u_trk (
        .mclk(mclk),
        .resetn(resetn),
        .ep(epi.trk)
      );
    end
  endgenerate

  assign erdy_any = |ep_erdy;
  assign all_idle = &ep_idle;

  // ----------------------------------------
  // Exit latency and bus interval
  // ----------------------------------------
  always_comb begin
    if (ctrl_r[`DLPP_CTRL_SELSRC]) begin
      u1_lat = {8'h00, sel_r[7:0]};
      u2_lat = sel_r[23:8];
    end else begin
      u1_lat = `DLPP_WC_U1_US;
      u2_lat = `DLPP_WC_U2_US;
    end
  end

  assign u2_thr = {1'b0, u2_lat} + {1'b0, guard_r};
  assign want_u2 = {1'b0, hint_r} > u2_thr;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bi_cnt_r <= 16'h0000;
    end else if (bi_sync) begin
      bi_cnt_r <= 16'h0000;
    end else if (us_tick && bi_cnt_r < 16'(BI_US)) begin
      bi_cnt_r <= bi_cnt_r + 16'h0001;
    end
  end

  assign bi_remain = 16'(BI_US) - bi_cnt_r;
  assign ts_blk1 = ctrl_r[`DLPP_CTRL_TSNEED] && bi_remain <= u1_lat;
  assign ts_blk2 = ctrl_r[`DLPP_CTRL_TSNEED] && bi_remain <= u2_lat;
  assign ts_wake = link_state == `DLPP_LINK_U2 ? ts_blk2 : ts_blk1;

  // ----------------------------------------
  // Entry and exit decisions
  // ----------------------------------------
  assign link_u0 = link_state == `DLPP_LINK_U0;
  assign link_lp = link_state == `DLPP_LINK_U1 || link_state == `DLPP_LINK_U2;
  assign allow_lp = all_idle && link_u0 && !tx_pend;
  assign allow_u2 = allow_lp && ctrl_r[`DLPP_CTRL_U2EN] && want_u2 && !ts_blk2;
  assign allow_u1 = allow_lp && ctrl_r[`DLPP_CTRL_U1EN] && !ts_blk1 &&
                    !(want_u2 && ctrl_r[`DLPP_CTRL_U2EN]);
  assign need_u0 = !all_idle || tx_pend || ts_wake;

  // ----------------------------------------
  // Policy state machine
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_ACTIVE: begin
        if (link_lp) begin
          st_nxt = ST_LOW;
        end else if (allow_u2) begin
          st_nxt = ST_ASK_U2;
        end else if (allow_u1) begin
          st_nxt = ST_ASK_U1;
        end
      end
      ST_ASK_U1: begin
        if (link_lp) begin
          st_nxt = ST_LOW;
        end else if (!allow_u1) begin
          st_nxt = ST_ACTIVE;
        end
      end
      ST_ASK_U2: begin
        if (link_lp) begin
          st_nxt = ST_LOW;
        end else if (!allow_u2) begin
          st_nxt = ST_ACTIVE;
        end
      end
      ST_LOW: begin
        if (link_u0) begin
          st_nxt = ST_ACTIVE;
        end else if (need_u0) begin
          st_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (link_u0) begin
          st_nxt = ST_ACTIVE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_ACTIVE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Link requests
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      req_u1 <= 1'b0;
      req_u2 <= 1'b0;
      req_u0 <= 1'b0;
    end else begin
      req_u1 <= st_nxt == ST_ASK_U1;
      req_u2 <= st_nxt == ST_ASK_U2;
      req_u0 <= st_nxt == ST_WAKE;
    end
  end

  // ----------------------------------------
  // Entry counters
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_u1_r <= 16'h0000;
      cnt_u2_r <= 16'h0000;
    end else if (wsel[6]) begin
      cnt_u1_r <= 16'h0000;
      cnt_u2_r <= 16'h0000;
    end else if (st_nxt == ST_LOW) begin
      if (st_r == ST_ASK_U1) begin
        cnt_u1_r <= cnt_u1_r + 16'h0001;
      end else if (st_r == ST_ASK_U2) begin
        cnt_u2_r <= cnt_u2_r + 16'h0001;
      end
    end
  end
endmodule : dlpp_top

`default_nettype wire

// *** include/dlpp_defs.svh ***
// Constants of the device link power policy block: offsets, fields,
// reset values and timing figures.
// Assumes a 40 MHz mclk and the 32-bit plain register port.
`ifndef DLPP_DEFS_SVH
`define DLPP_DEFS_SVH

// ----------------------------------------
// Clock and times
// ----------------------------------------
`define DLPP_CLK_MHZ 40
`define DLPP_TICK_NS 1000
`define DLPP_TICK_CYC ((`DLPP_TICK_NS * `DLPP_CLK_MHZ) / 1000)
`define DLPP_WC_U1_US 16'h000F
`define DLPP_WC_U2_US 16'h0805
`define DLPP_ERDY_TMO_US 500
`define DLPP_BI_US 125

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define DLPP_OFS_CTRL 8'h00
`define DLPP_OFS_SEL 8'h04
`define DLPP_OFS_GUARD 8'h08
`define DLPP_OFS_HINT 8'h0C
`define DLPP_OFS_EPTYPE 8'h10
`define DLPP_OFS_STATUS 8'h14
`define DLPP_OFS_COUNT 8'h18
`define DLPP_CTRL_RST 5'h00
`define DLPP_SEL_RST 24'h000000
`define DLPP_GUARD_RST 16'h0010
`define DLPP_EPTYPE_RST 8'hE4

// ----------------------------------------
// Fields
// ----------------------------------------
`define DLPP_CTRL_U1EN 0
`define DLPP_CTRL_U2EN 1
`define DLPP_CTRL_SELSRC 2
`define DLPP_CTRL_TSNEED 3
`define DLPP_CTRL_CONFIG 4
`define DLPP_LINK_U0 2'h0
`define DLPP_LINK_U1 2'h1
`define DLPP_LINK_U2 2'h2

`endif

// *** include/dlpp_pkg.sv ***
// Types shared by the link power policy modules.
// Assumes dlpp_defs.svh for all numeric constants other than EP_NUM.
`default_nettype none

package dlpp_pkg;
  localparam int EP_NUM = 4;
  typedef enum logic [1:0] {EP_CTRL, EP_BULK, EP_INTR, EP_ISO} dlpp_ep_kind_type;
  typedef enum logic [2:0] {ST_ACTIVE, ST_ASK_U1, ST_ASK_U2, ST_LOW, ST_WAKE} dlpp_st_type;
endpackage : dlpp_pkg

`default_nettype wire

// *** include/dlpp_ep_if.sv ***
// Carrier between the policy top and one endpoint tracker.
// Assumes all signals on mclk.
`default_nettype none

interface dlpp_ep_if;
  import dlpp_pkg::*;
  dlpp_ep_kind_type kind;
  logic nrdy, pp_clr, pp_set;
  logic erdy_sent, erdy_ans;
  logic burst_end, last_pkt, interval;
  logic us_tick, configured, ctl_busy, erdy_any;
  logic idle, erdy_pend;
  modport trk (
    input kind, nrdy, pp_clr, pp_set, erdy_sent, erdy_ans,
    input burst_end, last_pkt, interval, us_tick, configured,
    input ctl_busy, erdy_any,
    output idle, erdy_pend
  );
  modport top (
    output kind, nrdy, pp_clr, pp_set, erdy_sent, erdy_ans,
    output burst_end, last_pkt, interval, us_tick, configured,
    output ctl_busy, erdy_any,
    input idle, erdy_pend
  );
endinterface : dlpp_ep_if

`default_nettype wire

// *** design/dlpp_ep_track.sv ***
// Idle tracker of one endpoint.
// Assumes event inputs are one-cycle pulses on mclk.
`include "dlpp_defs.svh"
`default_nettype none

module dlpp_ep_track #(
  parameter int ERDY_TMO_US = `DLPP_ERDY_TMO_US
) (
  input wire logic mclk, // Clock
  input wire logic resetn, // Async reset, low
  dlpp_ep_if.trk ep // Endpoint events and idle result
);
  import dlpp_pkg::*;

  logic quiet_r;
  logic erdy_r;
  logic done_r;
  logic [15:0] tmo_r;
  logic tmo_hit;

  assign tmo_hit = erdy_r && ep.us_tick && (tmo_r == 16'(ERDY_TMO_US - 1));

  // ----------------------------------------
  // Flow control: NRDY or ACK without packets pending
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      quiet_r <= 1'b0;
    end else if (ep.nrdy || ep.pp_clr) begin
      quiet_r <= 1'b1;
    end else if (ep.pp_set) begin
      quiet_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pending ERDY, held until answered or timed out
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      erdy_r <= 1'b0;
      tmo_r <= 16'h0000;
    end else if (ep.erdy_sent) begin
      erdy_r <= 1'b1;
      tmo_r <= 16'h0000;
    end else if (ep.erdy_ans || tmo_hit) begin
      erdy_r <= 1'b0;
      tmo_r <= 16'h0000;
    end else if (erdy_r && ep.us_tick) begin
      tmo_r <= tmo_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // Service interval work done
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      done_r <= 1'b0;
    end else if ((ep.kind == EP_INTR && ep.burst_end) ||
                 (ep.kind == EP_ISO && ep.last_pkt)) begin
      done_r <= 1'b1;
    end else if (ep.interval) begin
      done_r <= 1'b0;
    end
  end

  always_comb begin
    unique case (ep.kind)
      EP_CTRL: ep.idle = ep.configured && !ep.ctl_busy && quiet_r && !ep.erdy_any;
      EP_BULK: ep.idle = quiet_r && !ep.erdy_any;
      EP_INTR: ep.idle = !ep.erdy_any && (quiet_r || done_r);
      EP_ISO: ep.idle = done_r;
    endcase
  end

  assign ep.erdy_pend = erdy_r;
endmodule : dlpp_ep_track

`default_nettype wire

// *** tb/dlpp_top_sva.sv ***
// Checker of the link power policy requests against their causes.
// Assumes ep0 stays control and ep1 bulk, as after reset.
`include "dlpp_defs.svh"
`default_nettype none

module dlpp_top_sva #(
  parameter int ERDY_TMO_US = `DLPP_ERDY_TMO_US,
  parameter int BI_US = `DLPP_BI_US
) (
  input wire logic mclk, // Clock
  input wire logic resetn, // Async reset, low
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic ctl_busy, // Control transfer busy
  input wire logic [1:0] link_state, // Link state
  input wire logic [dlpp_pkg::EP_NUM-1:0] ep_nrdy, // NRDY sent
  input wire logic [dlpp_pkg::EP_NUM-1:0] ep_pp_clr, // ACK, none pending
  input wire logic [dlpp_pkg::EP_NUM-1:0] ep_pp_set, // ACK, pending
  input wire logic [dlpp_pkg::EP_NUM-1:0] ep_erdy_sent, // ERDY sent
  input wire logic req_u1, // U1 request
  input wire logic req_u2, // U2 request
  input wire logic req_u0 // U0 request
);
  timeunit 1ns;
  timeprecision 1ps;
  import dlpp_pkg::*;
  logic u1en_r;
  logic u2en_r;
  logic low_r;
  logic low_now;
  logic bulk_set;

  // ----------------------------------------
  // Shadow of the enables and link history
  // ----------------------------------------
  assign low_now = link_state == `DLPP_LINK_U1 || link_state == `DLPP_LINK_U2;
  assign bulk_set = ep_pp_set[1] && !ep_nrdy[1] && !ep_pp_clr[1];
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      u1en_r <= 1'h0;
      u2en_r <= 1'h0;
    end else if (reg_wr && reg_addr == `DLPP_OFS_CTRL) begin
      u1en_r <= reg_wdata[`DLPP_CTRL_U1EN];
      u2en_r <= reg_wdata[`DLPP_CTRL_U2EN];
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      low_r <= 1'h0;
    end else begin
      low_r <= low_now;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_bulk_busy;
    bulk_set ##1 (!ep_nrdy[1] && !ep_pp_clr[1])[*3];
  endsequence
  a_u1_enable_gate: assert property (req_u1 |-> $past(u1en_r))
    else $error("U1 request without U1 enable");
  a_u2_enable_gate: assert property (req_u2 |-> $past(u2en_r))
    else $error("U2 request without U2 enable");
  a_one_target: assert property (!(req_u1 && req_u2) && !(req_u0 && (req_u1 || req_u2)))
    else $error("Two link targets requested at once");
  a_only_from_u0: assert property (link_state != `DLPP_LINK_U0 |=> !req_u1 && !req_u2)
    else $error("Low power request outside U0");
  a_bulk_blocks: assert property (s_bulk_busy |=> !req_u1 && !req_u2)
    else $error("Low power request with bulk endpoint busy");
  a_busy_blocks: assert property (ctl_busy |=> !req_u1 && !req_u2)
    else $error("Low power request during control transfer");
  a_erdy_holds: assert property (|ep_erdy_sent |-> ##2 (!req_u1 && !req_u2)[*8])
    else $error("Low power request with ERDY pending");
  a_erdy_wakes: assert property (|ep_erdy_sent && low_now && low_r |-> ##[1:2] req_u0)
    else $error("No wake after ERDY in low power");
  a_pp_wakes: assert property (bulk_set && low_now && low_r |-> ##[1:2] req_u0)
    else $error("No wake when bulk endpoint left idle");
  a_u0_release: assert property (req_u0 && link_state == `DLPP_LINK_U0 |=> !req_u0)
    else $error("Wake request held in U0");
endmodule : dlpp_top_sva

bind dlpp_top dlpp_top_sva #(.ERDY_TMO_US(ERDY_TMO_US), .BI_US(BI_US)) dlpp_top_sva_i (
  .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .ctl_busy(ctl_busy), .link_state(link_state), .ep_nrdy(ep_nrdy),
  .ep_pp_clr(ep_pp_clr), .ep_pp_set(ep_pp_set), .ep_erdy_sent(ep_erdy_sent),
  .req_u1(req_u1), .req_u2(req_u2), .req_u0(req_u0)
);

`default_nettype wire

// *** tb/dlpp_link_model.sv ***
// Link partner port: follows the device's requests after a delay.
// Assumes requests are levels held until the link state changes.
`include "dlpp_defs.svh"
`default_nettype none

module dlpp_link_model (
  input wire logic mclk, // Clock
  input wire logic resetn, // Async reset, low
  input wire logic req_u1, // Device asks for U1
  input wire logic req_u2, // Device asks for U2
  input wire logic req_u0, // Device asks for U0
  input wire logic [7:0] dly, // Answer delay in cycles
  input wire logic [7:0] tmo, // Own U1 inactivity timeout, 0 off
  output logic [1:0] link_state // Present link state
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wait_r;
  logic [7:0] idle_r;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      link_state <= `DLPP_LINK_U0;
      wait_r <= 8'h00;
      idle_r <= 8'h00;
    end else if (link_state == `DLPP_LINK_U0 ? (req_u1 || req_u2) : req_u0) begin
      wait_r <= wait_r + 8'h01;
      idle_r <= 8'h00;
      if (wait_r >= dly) begin
        wait_r <= 8'h00;
        link_state <= req_u0 ? `DLPP_LINK_U0 : (req_u2 ? `DLPP_LINK_U2 : `DLPP_LINK_U1);
      end
    end else begin
      wait_r <= 8'h00;
      // Own inactivity timer, entered without any device request
      idle_r <= (link_state == `DLPP_LINK_U0 && tmo != 8'h00) ? idle_r + 8'h01 : 8'h00;
      if (link_state == `DLPP_LINK_U0 && tmo != 8'h00 && idle_r == tmo) begin
        link_state <= `DLPP_LINK_U1;
      end
    end
  end
endmodule : dlpp_link_model

`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench of the link power policy with a link partner.
// Assumes the checker is bound to dlpp_top from its own file.
`include "dlpp_defs.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk;
  logic resetn;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic ctl_busy;
  logic tx_pend;
  logic bi_sync;
  logic [1:0] link_state;
  logic [3:0] evt [8];
  logic req_u1;
  logic req_u2;
  logic req_u0;
  logic [7:0] dly;
  logic [7:0] tmo;
  logic [31:0] rv;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] ctl_t [4] = '{32'h17, 32'h17, 32'h15, 32'h13};
  logic [31:0] hint_t [4] = '{32'h64, 32'h14, 32'h64, 32'h64};
  logic [1:0] want_t [4] = '{2'h2, 2'h1, 2'h1, 2'h1};

  dlpp_top #(.ERDY_TMO_US(5), .BI_US(20)) dlpp_top_i (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctl_busy(ctl_busy),
    .tx_pend(tx_pend), .bi_sync(bi_sync), .link_state(link_state), .ep_nrdy(evt[0]),
    .ep_pp_clr(evt[1]), .ep_pp_set(evt[2]), .ep_erdy_sent(evt[3]), .ep_erdy_ans(evt[4]),
    .ep_burst_end(evt[5]), .ep_last_pkt(evt[6]), .ep_interval(evt[7]),
    .req_u1(req_u1), .req_u2(req_u2), .req_u0(req_u0)
  );
  dlpp_link_model dlpp_link_model_i (
    .mclk(mclk), .resetn(resetn), .req_u1(req_u1), .req_u2(req_u2), .req_u0(req_u0),
    .dly(dly), .tmo(tmo), .link_state(link_state)
  );

  // ----------------------------------------
  // Clock, interval pulse and hang limit
  // ----------------------------------------
  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    bi_sync <= (cyc % 800) == 799;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic ev(input int k, input logic [3:0] m);
    @(posedge mclk);
    evt[k] <= m;
    @(posedge mclk);
    evt[k] <= 4'h0;
  endtask : ev
  // Codes 0..2 are req_u1, req_u2, req_u0; 4 + s is link state s
  function automatic logic probe(input int w);
    case (w)
      0: return req_u1;
      1: return req_u2;
      2: return req_u0;
      default: return link_state == 2'(w - 4);
    endcase
  endfunction : probe
  task automatic wait_on(input int w);
    int n;
    n = 0;
    while (probe(w) !== 1'h1 && n < 2000) begin
      tick(1);
      n++;
    end
    chk({31'h0, probe(w)}, 32'h1);
  endtask : wait_on

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    ctl_busy = 1'h0;
    tx_pend = 1'h0;
    resetn = 1'h0;
    dly = 8'h03;
    tmo = 8'h00;
    for (int i = 0; i < 8; i++) evt[i] = 4'h0;
    repeat (3) @(posedge mclk);
    resetn <= 1'h1;
    rd(`DLPP_OFS_CTRL, rv); chk(rv, 32'h0);
    rd(`DLPP_OFS_SEL, rv); chk(rv, 32'h0);
    rd(`DLPP_OFS_GUARD, rv); chk(rv, 32'h10);
    rd(`DLPP_OFS_EPTYPE, rv); chk(rv, 32'hE4);
    rd(8'h1C, rv); chk(rv, 32'h0);
    wr(`DLPP_OFS_CTRL, 32'h10);
    ev(0, 4'h7);
    ev(6, 4'h8);
    tick(40); chk({30'h0, req_u2, req_u1}, 32'h0);
    rd(`DLPP_OFS_STATUS, rv); chk(rv & 32'hF, 32'hF);
    tmo <= 8'h20; wait_on(5);
    tmo <= 8'h00; tick(10); chk({31'h0, req_u0}, 32'h0);
    ev(2, 4'h2); wait_on(2);
    wait_on(4); tick(2); chk({31'h0, req_u0}, 32'h0);
    wr(`DLPP_OFS_CTRL, 32'h11);
    dly <= 8'hF0;
    tick(20); chk({31'h0, req_u1}, 32'h0);
    ev(2, 4'h4);
    ev(5, 4'h4);
    ev(1, 4'h2); wait_on(0);
    ctl_busy <= 1'h1; tick(3); chk({31'h0, req_u1}, 32'h0);
    ctl_busy <= 1'h0; dly <= 8'h03; wait_on(5);
    ev(7, 4'h8); wait_on(2);
    wait_on(4);
    ev(6, 4'h8); wait_on(0);
    wait_on(5);
    ev(3, 4'h4); wait_on(2);
    wait_on(4); tick(100); chk({31'h0, req_u1}, 32'h0);
    wait_on(0);
    wait_on(5);
    ev(3, 4'h2); wait_on(2);
    wait_on(4); dly <= 8'hF0; tick(20); chk({31'h0, req_u1}, 32'h0);
    ev(4, 4'h2); tick(20); chk({31'h0, req_u1}, 32'h1);
    dly <= 8'h03; wait_on(5);
    wr(`DLPP_OFS_SEL, 32'h00000A02);
    for (int i = 0; i < 4; i++) begin
      ev(2, 4'h2); wait_on(2);
      wait_on(4);
      wr(`DLPP_OFS_CTRL, ctl_t[i]);
      wr(`DLPP_OFS_HINT, hint_t[i]);
      ev(0, 4'h2); wait_on(want_t[i] == 2'h2 ? 1 : 0);
      chk({30'h0, req_u2, req_u1}, {30'h0, want_t[i]});
      wait_on(want_t[i] == 2'h2 ? 6 : 5);
    end
    tx_pend <= 1'h1; wait_on(2);
    wait_on(4); tick(10); chk({31'h0, req_u1}, 32'h0);
    tx_pend <= 1'h0; wait_on(5);
    rd(`DLPP_OFS_COUNT, rv); chk(rv, 32'h00010008);
    @(posedge bi_sync); wr(`DLPP_OFS_CTRL, 32'h1D); wait_on(2);
    wait_on(4); tick(10); chk({31'h0, req_u1}, 32'h0);
    wait_on(0);
    tick(5);
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
